// *** rtl/tenbit_addr_match.sv ***
// Two-wire target front end matching up to four 10-bit own addresses
//
// Behaviour
// R1: First byte is prefix 11110, two high address bits, then read/write bit.
// R2: Second byte holds the low eight address bits, compared to finish matching.
// R3: Four independent 10-bit own addresses are held, each individually enabled.
// R4: Ack first byte when its two high bits equal any enabled own address.
// R5: Ack second byte only if all ten bits match one single own address.
// R6: Configuring party should give all own addresses identical high bits.
// R7: After full match accept data; otherwise ignore bus until next start.
`timescale 1ns/1ps
`default_nettype none
`include "tenbit_match_regs.svh"
module tenbit_addr_match
   import tenbit_match_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output var  logic       sda_o,
   output var  logic       sda_oe_o,
   input  wire logic [9:0] own_addr0_i,
   input  wire logic [9:0] own_addr1_i,
   input  wire logic [9:0] own_addr2_i,
   input  wire logic [9:0] own_addr3_i,
   input  wire logic [3:0] own_en_i,
   output var  logic       selected_o,
   output var  logic [1:0] match_idx_o,
   output var  logic       read_o,
   output var  logic [7:0] rx_data_o,
   output var  logic       rx_valid_o
);
   ////////////////////////////////////////////////////////////////////////
   logic scl_s;
   logic sda_s;
   logic scl_q;
   logic sda_q;

   pin_sync u_scl
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .pin_i     (scl_i),
      .level_o   (scl_s)
   );
   pin_sync u_sda
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .pin_i     (sda_i),
      .level_o   (sda_s)
   );

   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;

   ////////////////////////////////////////////////////////////////////////
   match_state_e state_q;
   match_state_e ret_q;
   logic [7:0]   sh_q;
   logic [3:0]   cnt_q;
   logic [3:0]   hi_hit_q;
   logic         ack_q;
   logic         drive_q;
   logic [1:0]   idx_q;
   logic         sel_q;
   logic         rd_q;
   logic [7:0]   rx_q;
   logic         rxv_q;

   // R3: four own addresses
   own_addr_t own [4];
   assign own[0] = own_addr0_i;
   assign own[1] = own_addr1_i;
   assign own[2] = own_addr2_i;
   assign own[3] = own_addr3_i;

   // Byte including the bit arriving now; sh_q alone is one bit short
   wire [7:0] low_byte = {sh_q[6:0], sda_s};
   // R1 R4: prefix check and per-address high-bit compare, kept per slot
   wire prefix_ok = (low_byte[7:3] == `TBM_PREFIX);
   wire [3:0] hi_hit;
   // R2 R5: low bits compared only within slots whose high bits hit
   wire [3:0] full_hit_n;
   genvar g;
   generate
      for (g = 0; g < `TBM_NUM_ADDR; g++)
      begin : g_cmp
         assign hi_hit[g]     = own_en_i[g] & prefix_ok
                                & (low_byte[2:1] == own[g][9:8]);
         assign full_hit_n[g] = hi_hit_q[g] & (low_byte == own[g][7:0]);
      end
   endgenerate

   function automatic logic [1:0] first_set(input logic [3:0] v);
      first_set = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
   endfunction

   wire byte_done = scl_rise & (cnt_q == 4'h7);

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
         state_q  <= ST_IDLE;
         ret_q    <= ST_IDLE;
         sh_q     <= 8'h00;
         cnt_q    <= 4'h0;
         hi_hit_q <= 4'h0;
         ack_q    <= 1'b0;
         drive_q  <= 1'b0;
         idx_q    <= 2'h0;
         sel_q    <= 1'b0;
         rd_q     <= 1'b0;
         rx_q     <= 8'h00;
         rxv_q    <= 1'b0;
      end
      else
      begin
         scl_q <= scl_s;
         sda_q <= sda_s;
         rxv_q <= 1'b0;
         if (scl_rise)
         begin
            sh_q  <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + 4'h1;
         end
         // R7: a start always restarts address phase, a stop ends all
         if (start_c)
         begin
            state_q <= ST_ADDR1;
            cnt_q   <= 4'h0;
            sel_q   <= 1'b0;
            drive_q <= 1'b0;
         end
         else if (stop_c)
         begin
            state_q <= ST_IDLE;
            sel_q   <= 1'b0;
            drive_q <= 1'b0;
         end
         else
         begin
            unique case (state_q)
               ST_IDLE, ST_SKIP:
                  drive_q <= 1'b0;
               ST_ADDR1:
                  if (byte_done)
                  begin
                     // R4: ack first byte on any high-bit hit
                     hi_hit_q <= hi_hit;
                     rd_q     <= sda_s;
                     ack_q    <= |hi_hit;
                     ret_q    <= (|hi_hit) ? ST_ADDR2 : ST_SKIP;
                     state_q  <= ST_ACK1;
                  end
               ST_ADDR2:
                  if (byte_done)
                  begin
                     // R5: ack only on one complete ten-bit match
                     ack_q   <= |full_hit_n;
                     idx_q   <= first_set(full_hit_n);
                     sel_q   <= |full_hit_n;
                     ret_q   <= (|full_hit_n) ? ST_DATA : ST_SKIP;
                     state_q <= ST_ACK1;
                  end
               ST_DATA:
                  if (byte_done)
                  begin
                     // R7: data accepted only after full match
                     rx_q    <= {sh_q[6:0], sda_s};
                     rxv_q   <= 1'b1;
                     ack_q   <= 1'b1;
                     ret_q   <= ST_DATA;
                     state_q <= ST_ACK1;
                  end
               ST_ACK1:
                  if (scl_fall)
                  begin
                     if (drive_q)
                     begin
                        drive_q <= 1'b0;
                        cnt_q   <= 4'h0;
                        state_q <= ret_q;
                     end
                     else
                     begin
                        drive_q <= ack_q;
                        cnt_q   <= 4'h0;
                        if (!ack_q)
                           state_q <= ST_SKIP;
                     end
                  end
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Open-drain: only ever pulls low during an acknowledge slot
   assign sda_o       = 1'b0;
   assign sda_oe_o    = drive_q;
   assign selected_o  = sel_q;
   assign match_idx_o = idx_q;
   assign read_o      = rd_q;
   assign rx_data_o   = rx_q;
   assign rx_valid_o  = rxv_q;
endmodule
`default_nettype wire

// *** pkg/tenbit_match_regs.svh ***
// Constants for the multi-address 10-bit target address matcher
`ifndef TENBIT_MATCH_REGS_SVH
`define TENBIT_MATCH_REGS_SVH
`define TBM_PREFIX        5'h1E
`define TBM_NUM_ADDR      4
`define TBM_SYNC_STAGES   3
`endif

// *** pkg/tenbit_match_pkg.sv ***
// Types shared by the 10-bit target address matcher
package tenbit_match_pkg;
   typedef logic [9:0] own_addr_t;
   typedef enum logic [5:0] {
      ST_IDLE  = 6'h01,
      ST_ADDR1 = 6'h02,
      ST_ACK1  = 6'h04,
      ST_ADDR2 = 6'h08,
      ST_DATA  = 6'h10,
      ST_SKIP  = 6'h20
   } match_state_e;
endpackage

// *** rtl/pin_sync.sv ***
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
`default_nettype none
module pin_sync
(
   input  wire logic sys_clk_i,
   input  wire logic reset_i,
   input  wire logic pin_i,
   output var  logic level_o
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic lvl_q;

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         s1_q  <= 1'b1;
         s2_q  <= 1'b1;
         s3_q  <= 1'b1;
         lvl_q <= 1'b1;
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // A change counts only once the later stages agree
         if (s2_q == s3_q)
            lvl_q <= s3_q;
      end
   end

   assign level_o = lvl_q;
endmodule
`default_nettype wire

// *** sim/i2c_ctrl_model.sv ***
// Behavioural two-wire bus controller that sends 10-bit addresses
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model
#(
   parameter int H = 20
)
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_o,
   output var  logic sda_rel_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_rel_o = 1'b1;
   end
   task automatic half();
      repeat (H) @(posedge clk_i);
      #1;
   endtask
   task automatic start();
      sda_rel_o = 1'b0;
      half();
      scl_o = 1'b0;
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 8; i >= 0; i--)
      begin
         half();
         sda_rel_o = (i > 0) ? b[i - 1] : 1'b1;
         half();
         scl_o = 1'b1;
         half();
         ack = ~sda_i;
         scl_o = 1'b0;
      end
   endtask
   task automatic stop();
      half();
      sda_rel_o = 1'b0;
      half();
      scl_o = 1'b1;
      half();
      sda_rel_o = 1'b1;
      half();
   endtask
endmodule
`default_nettype wire

// *** sim/tenbit_addr_match_sva.sv ***
// Port checker for the 10-bit target address matcher
`timescale 1ns/1ps
`default_nettype none
module tenbit_addr_match_sva
(
   input wire logic       sys_clk_i,
   input wire logic       reset_i,
   input wire logic       scl_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic [3:0] own_en_i,
   input wire logic       selected_o,
   input wire logic [1:0] match_idx_o,
   input wire logic       rx_valid_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   property p_low; sda_o == 1'b0; endproperty
   property p_oe_up; $rose(sda_oe_o) |-> !scl_i; endproperty
   property p_oe_dn; $fell(sda_oe_o) |-> !scl_i; endproperty
   property p_oe_hold; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
   property p_sel_ack; $rose(selected_o) |-> ##[1:40] sda_oe_o; endproperty
   property p_sel_en; selected_o |-> own_en_i[match_idx_o]; endproperty
   property p_idx; selected_o && $past(selected_o) |-> $stable(match_idx_o);
   endproperty
   property p_rx_sel; rx_valid_o |-> selected_o; endproperty
   property p_rx_one; rx_valid_o |=> !rx_valid_o; endproperty
   a_low: assert property (p_low) else $error("sda high");
   a_oe_up: assert property (p_oe_up) else $error("ack rise");
   a_oe_dn: assert property (p_oe_dn) else $error("ack fall");
   a_oe_hold: assert property (p_oe_hold) else $error("ack moved");
   a_sel_ack: assert property (p_sel_ack) else $error("no ack");
   a_sel_en: assert property (p_sel_en) else $error("off slot");
   a_idx: assert property (p_idx) else $error("index moved");
   a_rx_sel: assert property (p_rx_sel) else $error("rx unselected");
   a_rx_one: assert property (p_rx_one) else $error("rx long");
   c_sel: cover property ($rose(selected_o));
   c_rx: cover property (rx_valid_o);
   c_ack: cover property ($rose(sda_oe_o) && !selected_o);
endmodule
bind tenbit_addr_match tenbit_addr_match_sva chk_u (.sys_clk_i(sys_clk_i),
   .reset_i(reset_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .own_en_i(own_en_i), .selected_o(selected_o), .match_idx_o(match_idx_o),
   .rx_valid_o(rx_valid_o));
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the 10-bit target address matcher
`timescale 1ns/1ps
`default_nettype none
`include "tenbit_match_regs.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
   $display("BAD %0t mismatch", $time); end end
module tb
   import tenbit_match_pkg::*;
;
   logic       sys_clk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic       scl, rel, oe, sel, rd, rxv, ack;
   wire        sda;
   logic [1:0] idx;
   logic [7:0] rxd;
   logic [7:0] lfsr = 8'h19;
   logic [3:0] en = 4'hF;
   own_addr_t  own [4];
   logic [9:0] note_q [$];
   int         fail_count = 0;
   int         checks = 0;
   always #5 sys_clk_i = ~sys_clk_i;
   // Open drain: either party pulls low, pull-up otherwise
   assign sda = rel & ~oe;
   i2c_ctrl_model #(.H(20)) ctrl_u (.clk_i(sys_clk_i), .sda_i(sda),
      .scl_o(scl), .sda_rel_o(rel));
   tenbit_addr_match dut_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(oe),
      .own_addr0_i(own[0]), .own_addr1_i(own[1]), .own_addr2_i(own[2]),
      .own_addr3_i(own[3]), .own_en_i(en), .selected_o(sel),
      .match_idx_o(idx), .read_o(rd), .rx_data_o(rxd), .rx_valid_o(rxv));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction
   task automatic summarize();
      if (fail_count == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic xfer(input own_addr_t a, input logic rw,
      input logic [1:0] k, input logic e1, input logic e2);
      logic [7:0] d;
      ctrl_u.start();
      ctrl_u.wbyte({`TBM_PREFIX, a[9:8], rw}, ack);
      `CHK(ack, e1)
      if (e1)
      begin
         ctrl_u.wbyte(a[7:0], ack);
         `CHK(ack, e2)
         `CHK(sel, e2)
         if (e2)
            `CHK(rd, rw)
         repeat (2)
         begin
            d = rnd();
            if (e2)
               note_q.push_back({k, d});
            ctrl_u.wbyte(d, ack);
            `CHK(ack, e2)
         end
      end
      ctrl_u.stop();
   endtask
   always @(negedge sys_clk_i)
      if (rxv === 1'b1)
      begin
         if (note_q.size() == 0)
            `CHK(1'b1, 1'b0)
         else
            `CHK({idx, rxd}, note_q.pop_front())
      end
   initial
   begin
      // Distinct high bits per slot so mixed halves must be refused
      foreach (own[i])
         own[i] = {2'(i + 1), rnd()};
      repeat (16) @(posedge sys_clk_i);
      #1 reset_i = 1'b0;
      repeat (8) @(posedge sys_clk_i);
      for (int k = 0; k < 4; k++)
         xfer(own[k], 1'(k), 2'(k), 1'b1, 1'b1);
      xfer({own[0][9:8], own[1][7:0]}, 1'b0, 2'h0, 1'b1, 1'b0);
      en = 4'hE;
      xfer(own[0], 1'b0, 2'h0, 1'b0, 1'b0);
      xfer(own[1], 1'b1, 2'h1, 1'b1, 1'b1);
      en = 4'hF;
      foreach (own[i])
         own[i][9:8] = 2'h2;
      for (int k = 0; k < 4; k++)
         xfer(own[k], 1'b0, 2'(k), 1'b1, 1'b1);
      `CHK(note_q.size(), 0)
      summarize();
   end
   initial
   begin
      #1000000;
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
